// [rtl/swsc_defines.svh]
// constants of the stop-wake stabilisation and clock select block
`ifndef SWSC_DEFINES_SVH
`define SWSC_DEFINES_SVH

// register indexes; byte address is four times the index
`define SWSC_ADDR_W         22
`define SWSC_IDX_W          20
`define SWSC_IDX_STAB_STAT  20'hFFFA2
`define SWSC_IDX_STAB_SEL   20'hFFFA3
`define SWSC_IDX_CLK_CTRL   20'hFFFA4

// reset values
`define SWSC_STAB_SEL_RST   3'h7
`define SWSC_CLK_CTRL_RST   8'h09

// clock control field positions
`define SWSC_CLS_BIT        7
`define SWSC_CSS_BIT        6
`define SWSC_MCS_BIT        5
`define SWSC_MCM_BIT        4
`define SWSC_SUB_DIVIDER_BIT       3
`define SWSC_MDIV_HI        2
`define SWSC_MDIV_LO        0
`define SWSC_MDIV_MAX       3'h5

// stabilisation wait exponents per select code
`define SWSC_CNT_W          19
`define SWSC_EXP0           5'h08
`define SWSC_EXP1           5'h09
`define SWSC_EXP2           5'h0A
`define SWSC_EXP3           5'h0B
`define SWSC_EXP4           5'h0D
`define SWSC_EXP5           5'h0F
`define SWSC_EXP6           5'h11
`define SWSC_EXP7           5'h12

// bus answers
`define SWSC_RESP_OKAY      2'h0
`define SWSC_RESP_SLVERR    2'h2

`endif

// [rtl/swsc_pkg.sv]
// types of the stop-wake stabilisation and clock select block
package swsc_pkg;
`include "swsc_defines.svh"

	typedef struct packed {
		logic stage1;
		logic stage2;
		logic last;
	} swsc_sync_state_type;

	typedef struct packed {
		logic                   run;
		logic [`SWSC_CNT_W-1:0] cnt;
		logic [7:0]             status;
	} swsc_cnt_state_type;

	typedef struct packed {
		logic                   awRdy;
		logic                   wRdy;
		logic                   haveAw;
		logic                   haveW;
		logic [`SWSC_IDX_W-1:0] awIdx;
		logic [7:0]             wByte;
		logic                   wLane0;
		logic                   bValid;
		logic [1:0]             bResp;
		logic                   arRdy;
		logic                   rValid;
		logic [1:0]             rResp;
		logic [31:0]            rData;
		logic [2:0]             stabSel;
		logic                   subclock_select;
		logic                   mcm;
		logic                   sub_divider;
		logic [2:0]             mdiv;
		logic                   oscStopLast;
		logic                   cpuHold;
	} swsc_top_state_type;
endpackage

// [rtl/swsc_sync.sv]
// two-flop synchroniser with rising edge detect for the crystal pin
`timescale 1ns/10ps
module swsc_sync (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic srst,
	// asynchronous pin
	input  wire logic pinIn,
	// one-cycle pulse on each rising edge seen
	output logic      rise
);
	import swsc_pkg::*;

	swsc_sync_state_type stateQ;
	swsc_sync_state_type stateD;

	always_comb begin
		stateD        = stateQ;
		stateD.stage1 = pinIn;
		stateD.stage2 = stateQ.stage1;
		// edge taken after the second flop only
		stateD.last   = stateQ.stage2;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stateQ <= '0;
		end else begin
			stateQ <= stateD;
		end
	end

	assign rise = stateQ.stage2 & ~stateQ.last;
endmodule

// [rtl/swsc_stab_counter.sv]
// crystal stabilisation counter with sticky threshold status
`timescale 1ns/10ps
`include "swsc_defines.svh"
module swsc_stab_counter (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// control
	input  wire logic       clear,
	input  wire logic       start,
	input  wire logic       xtalTick,
	input  wire logic [2:0] stabSel,
	// state
	output logic [7:0]      status,
	output logic            done
);
	import swsc_pkg::*;

	swsc_cnt_state_type stateQ;
	swsc_cnt_state_type stateD;

	function automatic logic [`SWSC_CNT_W-1:0] limitOf(
		input logic [2:0] code
	);
		logic [4:0] expo;
		unique case (code)
			3'h0: expo = `SWSC_EXP0;
			3'h1: expo = `SWSC_EXP1;
			3'h2: expo = `SWSC_EXP2;
			3'h3: expo = `SWSC_EXP3;
			3'h4: expo = `SWSC_EXP4;
			3'h5: expo = `SWSC_EXP5;
			3'h6: expo = `SWSC_EXP6;
			3'h7: expo = `SWSC_EXP7;
		endcase
		limitOf = `SWSC_CNT_W'(1) << expo;
	endfunction

	always_comb begin
		logic [`SWSC_CNT_W-1:0] nextCnt;
		nextCnt = stateQ.cnt + `SWSC_CNT_W'(1);
		stateD  = stateQ;
		if (clear) begin
			stateD = '0;
		end else if (start) begin
			stateD.cnt    = '0;
			stateD.status = '0;
			stateD.run    = 1'b1;
		end else if (stateQ.run && xtalTick) begin
			// only real crystal edges advance the count
			stateD.cnt = nextCnt;
			for (int i = 0; i < 8; i++) begin
				if (3'(i) <= stabSel && nextCnt >= limitOf(3'(i))) begin
					stateD.status[7-i] = 1'b1;
				end
			end
			if (nextCnt >= limitOf(stabSel)) begin
				stateD.run = 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stateQ <= '0;
		end else begin
			stateQ <= stateD;
		end
	end

	assign status = stateQ.status;
	assign done   = stateQ.status[3'h7 - stabSel];
endmodule

// [rtl/swsc_clock_ctrl.sv]
// stop-wake stabilisation select and system clock control, AXI4-Lite
// How it works
// - select code 0..7 waits 2^8,9,10,11,13,15,17,18 crystal periods
// - crystal-clocked CPU is held after stop release until wait ends
// - select register takes whole-byte writes only, resets to 07H
// - counter stops at selected wait, no status beyond it
// - wait counted only from real crystal oscillation edges
// - clock control resets to 09H, internal clock halved, byte writes
// - bits 7 and 5 of clock control are read-only status
// - bit 7 reads 1 when subsystem clock feeds CPU, else 0
// - bit 5 reads 1 when high-speed system clock is main source
// - main divider codes 0..5 divide main source by 1 to 32
// - with subclock select set, sub divider picks sub clock or half
// - new selection reaches CPU and peripherals in the same cycle
// - status bits set one by one from lowest threshold, stay set
// - status clears on reset, stop entry and oscillator stop
// - counting starts at oscillation start and at stop release
`timescale 1ns/10ps
`include "swsc_defines.svh"
module swsc_clock_ctrl (
	// clock and reset
	input  wire logic                     core_clk,
	input  wire logic                     srst,
	// AXI4-Lite write address and data
	input  wire logic [`SWSC_ADDR_W-1:0]  s_axi_awaddr,
	input  wire logic                     s_axi_awvalid,
	output logic                          s_axi_awready,
	input  wire logic [31:0]              s_axi_wdata,
	input  wire logic [3:0]               s_axi_wstrb,
	input  wire logic                     s_axi_wvalid,
	output logic                          s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                    s_axi_bresp,
	output logic                          s_axi_bvalid,
	input  wire logic                     s_axi_bready,
	// AXI4-Lite read
	input  wire logic [`SWSC_ADDR_W-1:0]  s_axi_araddr,
	input  wire logic                     s_axi_arvalid,
	output logic                          s_axi_arready,
	output logic [31:0]                   s_axi_rdata,
	output logic [1:0]                    s_axi_rresp,
	output logic                          s_axi_rvalid,
	input  wire logic                     s_axi_rready,
	// power mode events from the core, same clock
	input  wire logic                     stopEnter,
	input  wire logic                     stopRelease,
	input  wire logic                     hsOscStop,
	// crystal pin, asynchronous
	input  wire logic                     mainCrystal,
	// CPU hold after stop release
	output logic                          cpuHold,
	// applied clock selection to CPU and peripherals
	output logic                          fclkSubSelect,
	output logic                          fclkMainXtal,
	output logic                          fclkSubHalf,
	output logic [2:0]                    fclkMainDiv
);
	import swsc_pkg::*;

	swsc_top_state_type stateQ;
	swsc_top_state_type stateD;

	logic       xtalTick;
	logic [7:0] stabStatus;
	logic       stabDone;
	logic       cntClear;
	logic       cntStart;

	swsc_sync u_xtal_sync (
		.core_clk (core_clk),
		.srst     (srst),
		.pinIn    (mainCrystal),
		.rise     (xtalTick)
	);

	swsc_stab_counter u_stab_counter (
		.core_clk (core_clk),
		.srst     (srst),
		.clear    (cntClear),
		.start    (cntStart),
		.xtalTick (xtalTick),
		.stabSel  (stateQ.stabSel),
		.status   (stabStatus),
		.done     (stabDone)
	);

	// stop entry and a stopped oscillator both wipe the status
	assign cntClear = stopEnter | hsOscStop;
	// oscillator restart or stop release begins a new count
	assign cntStart = stopRelease |
		(stateQ.oscStopLast & ~hsOscStop);

	function automatic logic [7:0] ctrlByte(
		input swsc_top_state_type s
	);
		ctrlByte                  = '0;
		ctrlByte[`SWSC_CLS_BIT]   = s.subclock_select;
		ctrlByte[`SWSC_CSS_BIT]   = s.subclock_select;
		ctrlByte[`SWSC_MCS_BIT]   = s.mcm;
		ctrlByte[`SWSC_MCM_BIT]   = s.mcm;
		ctrlByte[`SWSC_SUB_DIVIDER_BIT]  = s.sub_divider;
		ctrlByte[`SWSC_MDIV_HI:`SWSC_MDIV_LO] = s.mdiv;
	endfunction

	always_comb begin
		logic [`SWSC_IDX_W-1:0] rdIdx;
		logic [7:0]             wb;
		rdIdx  = s_axi_araddr[`SWSC_ADDR_W-1:2];
		wb     = '0;
		stateD = stateQ;
		stateD.oscStopLast = hsOscStop;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && stateQ.awRdy) begin
			stateD.haveAw = 1'b1;
			stateD.awIdx  = s_axi_awaddr[`SWSC_ADDR_W-1:2];
		end
		if (s_axi_wvalid && stateQ.wRdy) begin
			stateD.haveW  = 1'b1;
			stateD.wByte  = s_axi_wdata[7:0];
			stateD.wLane0 = s_axi_wstrb[0];
		end
		if (stateQ.bValid && s_axi_bready) begin
			stateD.bValid = 1'b0;
		end
		if (stateD.haveAw && stateD.haveW && !stateD.bValid) begin
			stateD.haveAw = 1'b0;
			stateD.haveW  = 1'b0;
			stateD.bValid = 1'b1;
			stateD.bResp  = `SWSC_RESP_OKAY;
			wb            = stateD.wByte;
			unique case (stateD.awIdx)
				`SWSC_IDX_STAB_SEL: begin
					// partial lanes do not reach this byte
					if (stateD.wLane0) begin
						stateD.stabSel = wb[2:0];
					end
				end
				`SWSC_IDX_CLK_CTRL: begin
					// status bits 7 and 5 are not stored from the bus
					if (stateD.wLane0 && (wb[`SWSC_CSS_BIT] ||
						wb[`SWSC_MDIV_HI:`SWSC_MDIV_LO] <=
						`SWSC_MDIV_MAX)) begin
						stateD.subclock_select  = wb[`SWSC_CSS_BIT];
						stateD.mcm  = wb[`SWSC_MCM_BIT];
						stateD.sub_divider = wb[`SWSC_SUB_DIVIDER_BIT];
						stateD.mdiv =
							wb[`SWSC_MDIV_HI:`SWSC_MDIV_LO];
					end
				end
				`SWSC_IDX_STAB_STAT: begin
					// read-only, write accepted and dropped
				end
				default: begin
					stateD.bResp = `SWSC_RESP_SLVERR;
				end
			endcase
		end
		stateD.awRdy = !stateD.haveAw && !stateD.bValid;
		stateD.wRdy  = !stateD.haveW && !stateD.bValid;

		// read channel
		if (stateQ.rValid && s_axi_rready) begin
			stateD.rValid = 1'b0;
		end
		if (s_axi_arvalid && stateQ.arRdy) begin
			stateD.rValid = 1'b1;
			stateD.rResp  = `SWSC_RESP_OKAY;
			stateD.rData  = '0;
			unique case (rdIdx)
				`SWSC_IDX_STAB_STAT:
					stateD.rData[7:0] = stabStatus;
				`SWSC_IDX_STAB_SEL:
					stateD.rData[2:0] = stateQ.stabSel;
				`SWSC_IDX_CLK_CTRL:
					stateD.rData[7:0] = ctrlByte(stateQ);
				default:
					stateD.rResp = `SWSC_RESP_SLVERR;
			endcase
		end
		stateD.arRdy = !stateD.rValid;

		// hold CPU on the crystal until the selected wait has run
		if (stopRelease && !stateQ.subclock_select && stateQ.mcm) begin
			stateD.cpuHold = 1'b1;
		end else if (stabDone && !cntStart) begin
			stateD.cpuHold = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			stateQ         <= '0;
			stateQ.stabSel <= `SWSC_STAB_SEL_RST;
			stateQ.subclock_select     <= 1'(`SWSC_CLK_CTRL_RST >> `SWSC_CSS_BIT);
			stateQ.mcm     <= 1'(`SWSC_CLK_CTRL_RST >> `SWSC_MCM_BIT);
			stateQ.sub_divider    <= 1'(`SWSC_CLK_CTRL_RST >> `SWSC_SUB_DIVIDER_BIT);
			// oscillator counts as stopped, so its first start counts
			stateQ.oscStopLast <= 1'b1;
			stateQ.mdiv    <= 3'(`SWSC_CLK_CTRL_RST);
		end else begin
			stateQ <= stateD;
		end
	end

	assign s_axi_awready = stateQ.awRdy;
	assign s_axi_wready  = stateQ.wRdy;
	assign s_axi_bvalid  = stateQ.bValid;
	assign s_axi_bresp   = stateQ.bResp;
	assign s_axi_arready = stateQ.arRdy;
	assign s_axi_rvalid  = stateQ.rValid;
	assign s_axi_rresp   = stateQ.rResp;
	assign s_axi_rdata   = stateQ.rData;
	assign cpuHold       = stateQ.cpuHold;
	// one register feeds all selection outputs so they switch together
	assign fclkSubSelect = stateQ.subclock_select;
	assign fclkMainXtal  = stateQ.mcm;
	assign fclkSubHalf   = stateQ.sub_divider;
	assign fclkMainDiv   = stateQ.mdiv;
endmodule

// [verif/swsc_xtal_model.sv]
// crystal oscillator model driving the crystal pin
`timescale 1ns/10ps
module swsc_xtal_model #(
	parameter int HALF_NS  = 100,
	parameter int START_NS = 2000
) (
	// enable from the oscillator stop control, low = stopped
	input  wire logic run,
	// crystal pin
	output logic      pin
);
	initial pin = 1'b0;
	always begin
		wait (run);
		// no edges during the start-up delay
		#START_NS;
		while (run) begin
			#HALF_NS pin = ~pin;
		end
		pin = 1'b0;
	end
endmodule

// [verif/swsc_ctrl_assertions.sv]
// port assertions for the clock control block
`timescale 1ns/10ps
module swsc_ctrl_checker (
	// clock and reset
	input wire logic       core_clk,
	input wire logic       srst,
	// bus handshakes
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic       s_axi_rvalid,
	// power events and clock selection
	input wire logic       stopRelease,
	input wire logic       cpuHold,
	input wire logic       fclkSubSelect,
	input wire logic       fclkMainXtal,
	input wire logic       fclkSubHalf,
	input wire logic [2:0] fclkMainDiv
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (srst);
	sequence wrTaken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence holdWait;
		cpuHold [*8];
	endsequence
	AST_RST_SEL: assert property (
		$fell(srst) |-> !fclkSubSelect && !fclkMainXtal && fclkSubHalf
			&& fclkMainDiv == 3'h1 && !cpuHold)
		else $error("selection not at reset value");
	AST_WR_ANS: assert property (
		wrTaken |=> s_axi_bvalid && !s_axi_awready)
		else $error("write not answered");
	AST_RD_ANS: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	AST_SEL_SYNC: assert property (
		!$stable({fclkSubSelect, fclkMainXtal, fclkSubHalf, fclkMainDiv})
			|-> $rose(s_axi_bvalid))
		else $error("selection changed outside a write");
	AST_DIV_OK: assert property (
		!fclkSubSelect |-> fclkMainDiv <= 3'h5)
		else $error("prohibited divider applied");
	AST_HOLD_SET: assert property (
		stopRelease && !fclkSubSelect && fclkMainXtal |=> cpuHold)
		else $error("core not held");
	AST_NO_HOLD: assert property (
		stopRelease && !fclkMainXtal && !cpuHold |=> !cpuHold)
		else $error("core held on internal clock");
	AST_HOLD_MIN: assert property (
		$rose(cpuHold) |-> holdWait)
		else $error("hold too short");
endmodule
bind swsc_clock_ctrl swsc_ctrl_checker chk_u (.*);

// [verif/tb.sv]
// self-checking bench for the clock control block
`timescale 1ns/10ps
module tb;
	localparam logic [21:0] ADR_STAT = 22'h3FFE88;
	localparam logic [21:0] ADR_SEL  = 22'h3FFE8C;
	localparam logic [21:0] ADR_CLK  = 22'h3FFE90;
	typedef struct packed {
		logic w; logic [21:0] a; logic [7:0] d;
		logic [3:0] s; logic [7:0] e; logic [1:0] r;
	} swsc_row_type;
	logic        core_clk, srst, stopEnter, stopRelease;
	logic        hsOscStop, mainCrystal, cpuHold, fclkSubSelect;
	logic        fclkMainXtal, fclkSubHalf;
	logic [2:0]  fclkMainDiv;
	logic [21:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, dat;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
	int          fail_count = 0, check_count = 0, n;
	swsc_row_type rows [12] = '{
		'{0, ADR_SEL, 8'h00, 4'h0, 8'h07, 2'h0},
		'{0, ADR_CLK, 8'h00, 4'h0, 8'h09, 2'h0},
		'{0, ADR_STAT, 8'h00, 4'h0, 8'h00, 2'h0},
		'{1, ADR_CLK, 8'hA2, 4'h1, 8'h02, 2'h0},
		'{1, ADR_CLK, 8'h48, 4'h1, 8'hC8, 2'h0},
		'{1, ADR_CLK, 8'h08, 4'h1, 8'h08, 2'h0},
		'{1, ADR_CLK, 8'h14, 4'h1, 8'h34, 2'h0},
		'{1, ADR_CLK, 8'h06, 4'h1, 8'h34, 2'h0},
		'{1, ADR_SEL, 8'h00, 4'h1, 8'h00, 2'h0},
		'{1, ADR_SEL, 8'h05, 4'h0, 8'h00, 2'h0},
		'{1, ADR_STAT, 8'h55, 4'h1, 8'h00, 2'h0},
		'{1, 22'h0, 8'h11, 4'h1, 8'h00, 2'h2}
	};
	swsc_clock_ctrl dut_u (.*);
	swsc_xtal_model xtal_u (.run(!hsOscStop), .pin(mainCrystal));
	initial begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	task automatic finish_test();
		if (fail_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// every handshake and poll loop waits here so a hang ends the run
	task automatic tick(inout int k);
		@(posedge core_clk);
		k++;
		if (k > 6000) begin
			fail_count++;
			finish_test();
		end
	endtask
	task automatic wr(input logic [21:0] a, input logic [7:0] d,
		input logic [3:0] s);
		int k;
		k = 0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			tick(k);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [21:0] a);
		int k;
		k = 0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			tick(k);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		dat = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic pulse(input logic rel);
		@(posedge core_clk);
		stopRelease <= rel;
		stopEnter <= !rel;
		@(posedge core_clk);
		stopRelease <= 1'b0;
		stopEnter <= 1'b0;
	endtask
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, stopEnter, stopRelease} = '0;
		srst = 1'b1;
		hsOscStop = 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		// crystal stays stopped so select writes never meet a count
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d, rows[i].s);
				chk({30'h0, rsp}, {30'h0, rows[i].r});
			end
			rd(rows[i].a);
			chk(dat, {24'h0, rows[i].e});
			chk({30'h0, rsp}, {30'h0, rows[i].r});
		end
		chk({26'h0, fclkSubSelect, fclkMainXtal, fclkSubHalf,
			fclkMainDiv}, 32'h14);
		// code 0 is 51.2 us on the 5 MHz model crystal
		hsOscStop <= 1'b0;
		n = 0;
		do begin
			rd(ADR_STAT);
			tick(n);
		end while (dat !== 32'h80);
		// start-up delay plus 256 periods, four cycles per poll
		chk(32'(n > 328 && n < 340), 32'h1);
		// count finished, so the select may be rewritten
		wr(ADR_SEL, 8'h00, 4'h1);
		chk({30'h0, rsp}, 32'h0);
		// crystal-clocked core, shortest wait code 0
		wr(ADR_CLK, 8'h11, 4'h1);
		pulse(1'b0);
		rd(ADR_STAT);
		chk(dat, 32'h0);
		pulse(1'b1);
		n = 0;
		do tick(n); while (cpuHold === 1'b1);
		// 256 crystal periods of 5 core cycles plus pipeline
		chk(32'(n > 1270 && n < 1300), 32'h1);
		rd(ADR_STAT);
		chk(dat, 32'h80);
		wr(ADR_CLK, 8'h01, 4'h1);
		pulse(1'b1);
		@(posedge core_clk);
		chk({31'h0, cpuHold}, 32'h0);
		hsOscStop <= 1'b1;
		rd(ADR_STAT);
		chk(dat, 32'h0);
		// second reset in mid-run restores every selection
		srst <= 1'b1;
		repeat (3) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		chk({26'h0, fclkSubSelect, fclkMainXtal, fclkSubHalf,
			fclkMainDiv}, 32'h09);
		chk({31'h0, cpuHold}, 32'h0);
		rd(ADR_SEL);
		chk(dat, 32'h07);
		rd(ADR_CLK);
		chk(dat, 32'h09);
		finish_test();
	end
endmodule
